// >>> token_net_regs.svh
`ifndef TOKEN_NET_REGS_SVH
`define TOKEN_NET_REGS_SVH

// Byte offsets within the core's page of external data space
`define OFS_PTR_UPPER      8'h02
`define OFS_PTR_LOWER      8'h03
`define OFS_RAM_DATA       8'h04
`define OFS_CONFIG         8'h06

// Upper pointer register fields
`define UPR_DIR_BIT        7
`define UPR_STEP_BIT       6
`define UPR_ADDR_MSB       1
`define UPR_ADDR_LSB       0
`define UPR_RSVD_VALUE     4'h0

// Configuration register fields
`define CFG_SRST_BIT       7
`define CFG_CHAIN_BIT      6
`define CFG_TXGATE_BIT     5
`define CFG_TO_HI_BIT      4
`define CFG_TO_LO_BIT      3

// Reset values
`define CFG_RESET          8'h00
`define PTR_ADDR_RESET     10'h000
`define BYTE_ZERO          8'h00

// Clock and protocol times at 2.5 Mbps
`define CLK_PERIOD_NS      5.0
`define NS_PER_US          1000.0
`define NS_PER_MS          1000000.0
`define RESP_T00_US        1193.6
`define RESP_T01_US        596.8
`define RESP_T10_US        298.4
`define IDLE_T00_US        1312.0
`define IDLE_T01_US        656.0
`define IDLE_T10_US        328.0
`define RECON_T_MS         1680.0

`endif

// >>> token_net_pkg.sv
package token_net_pkg;

   typedef logic [9:0]  ram_addr_t;
   typedef logic [31:0] cycles_t;

   typedef enum logic [1:0]
   {
      TO_FULL    = 2'b00,
      TO_HALF    = 2'b01,
      TO_QUARTER = 2'b10,
      TO_SPARE   = 2'b11
   } timeout_sel_t;

   typedef enum logic [1:0]
   {
      FETCH_IDLE    = 2'b00,
      FETCH_ISSUE   = 2'b01,
      FETCH_CAPTURE = 2'b10
   } fetch_state_t;

   // Whole 10-bit step, wraps from the top address to zero
   function automatic ram_addr_t step_address(input ram_addr_t addr);
      step_address = addr + 10'h001;
   endfunction : step_address

endpackage : token_net_pkg

// >>> pointer_if.sv
`timescale 1ns/1ps
interface pointer_if;
   import token_net_pkg::*;

   logic       load_upper;
   logic       load_lower;
   logic       step;
   logic [7:0] wdata;
   logic       read_direction;
   logic       pointer_step_enable;
   ram_addr_t  addr;

   modport ctl (output load_upper, output load_lower, output step, output wdata,
                input read_direction, input pointer_step_enable, input addr);
   modport ptr (input load_upper, input load_lower, input step, input wdata,
                output read_direction, output pointer_step_enable, output addr);
endinterface : pointer_if

// >>> ram_pointer.sv
`timescale 1ns/1ps
`include "token_net_regs.svh"
module ram_pointer
   import token_net_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control from register decode
   pointer_if.ptr    pif
);

   logic      dir_r;
   logic      dir_nxt;
   logic      step_en_r;
   logic      step_en_nxt;
   ram_addr_t addr_r;
   ram_addr_t addr_nxt;

   always_comb
   begin
      dir_nxt     = dir_r;
      step_en_nxt = step_en_r;
      addr_nxt    = addr_r;
      // A software load outranks a pending step
      if (pif.load_upper || pif.load_lower)
      begin
         if (pif.load_upper)
         begin
            dir_nxt     = pif.wdata[`UPR_DIR_BIT];
            step_en_nxt = pif.wdata[`UPR_STEP_BIT];
            addr_nxt[9:8] = pif.wdata[`UPR_ADDR_MSB:`UPR_ADDR_LSB];
         end
         if (pif.load_lower)
         begin
            addr_nxt[7:0] = pif.wdata;
         end
      end
      else if (pif.step && step_en_r)
      begin
         addr_nxt = step_address(addr_r);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dir_r     <= 1'b0;
         step_en_r <= 1'b0;
         addr_r    <= `PTR_ADDR_RESET;
      end
      else
      begin
         dir_r     <= dir_nxt;
         step_en_r <= step_en_nxt;
         addr_r    <= addr_nxt;
      end
   end

   assign pif.read_direction      = dir_r;
   assign pif.pointer_step_enable = step_en_r;
   assign pif.addr                = addr_r;

endmodule : ram_pointer

// >>> token_net_host_pointer_config.sv
`timescale 1ns/1ps
`include "token_net_regs.svh"
module token_net_host_pointer_config
   import token_net_pkg::*;
#(
   parameter cycles_t RESP00_CYC  = cycles_t'(int'(`RESP_T00_US * `NS_PER_US / `CLK_PERIOD_NS)),
   parameter cycles_t RESP01_CYC  = cycles_t'(int'(`RESP_T01_US * `NS_PER_US / `CLK_PERIOD_NS)),
   parameter cycles_t RESP10_CYC  = cycles_t'(int'(`RESP_T10_US * `NS_PER_US / `CLK_PERIOD_NS)),
   parameter cycles_t RESP11_CYC  = RESP10_CYC,
   parameter cycles_t IDLE00_CYC  = cycles_t'(int'(`IDLE_T00_US * `NS_PER_US / `CLK_PERIOD_NS)),
   parameter cycles_t IDLE01_CYC  = cycles_t'(int'(`IDLE_T01_US * `NS_PER_US / `CLK_PERIOD_NS)),
   parameter cycles_t IDLE10_CYC  = cycles_t'(int'(`IDLE_T10_US * `NS_PER_US / `CLK_PERIOD_NS)),
   parameter cycles_t IDLE11_CYC  = IDLE10_CYC,
   parameter cycles_t RECON_CYC   = cycles_t'(int'(`RECON_T_MS * `NS_PER_MS / `CLK_PERIOD_NS)),
   parameter cycles_t RECON11_CYC = RECON_CYC
)
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Microcontroller external data access
   input  wire logic [7:0] bus_addr_i,
   input  wire logic [7:0] bus_wdata_i,
   input  wire logic       bus_wr_i,
   input  wire logic       bus_rd_i,
   output logic      [7:0] bus_rdata_o,
   // Packet RAM port
   output logic      [9:0] ram_addr_o,
   output logic            ram_wr_o,
   output logic            ram_rd_o,
   output logic      [7:0] ram_wdata_o,
   input  wire logic [7:0] ram_rdata_i,
   // Transmit requests from the protocol engine
   input  wire logic       tx_pulse_a_req_i,
   input  wire logic       tx_pulse_b_req_i,
   input  wire logic       tx_driver_req_i,
   input  wire logic       backplane_mode_i,
   // Line pins
   output logic            line_drive_pulse_a_n_o,
   output logic            line_drive_pulse_b_n_o,
   output logic            line_driver_enable_n_o,
   // Core control
   output logic            core_soft_reset_o,
   output logic            status_reinit_o,
   output logic            chained_command_enable_o,
   output logic      [1:0] timeout_select_o,
   output cycles_t         response_cycles_o,
   output cycles_t         idle_cycles_o,
   output cycles_t         reconfig_cycles_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   function automatic cycles_t pick(input logic [1:0] sel, input cycles_t c00,
                                    input cycles_t c01, input cycles_t c10,
                                    input cycles_t c11);
      case (timeout_sel_t'(sel))
         TO_FULL:    pick = c00;
         TO_HALF:    pick = c01;
         TO_QUARTER: pick = c10;
         default:    pick = c11;
      endcase
   endfunction : pick

   ////////////////////////////////////////////////////////////////////////////////
   // Pointer unit

   pointer_if pif ();

   ram_pointer u_ptr
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pif   (pif)
   );

   logic wr_upper;
   logic wr_lower;
   logic wr_data;
   logic wr_cfg;
   logic rd_data;

   assign wr_upper = bus_wr_i && hit(bus_addr_i, `OFS_PTR_UPPER);
   assign wr_lower = bus_wr_i && hit(bus_addr_i, `OFS_PTR_LOWER);
   assign wr_data  = bus_wr_i && hit(bus_addr_i, `OFS_RAM_DATA);
   assign wr_cfg   = bus_wr_i && hit(bus_addr_i, `OFS_CONFIG);
   assign rd_data  = bus_rd_i && hit(bus_addr_i, `OFS_RAM_DATA);

   ////////////////////////////////////////////////////////////////////////////////
   // Register file and RAM access

   logic [7:0]   cfg_r;
   logic [7:0]   cfg_nxt;
   logic [7:0]   rdata_r;
   logic [7:0]   rdata_nxt;
   logic [7:0]   prefetch_r;
   logic [7:0]   prefetch_nxt;
   logic [7:0]   wdata_r;
   logic [7:0]   wdata_nxt;
   logic         ram_wr_r;
   logic         ram_wr_nxt;
   logic         rd_step_r;
   logic         rd_step_nxt;
   logic         ptr_load_r;
   logic         ptr_load_nxt;
   logic         pend_r;
   logic         pend_nxt;
   fetch_state_t fetch_r;
   fetch_state_t fetch_nxt;

   // Step after the access has used the old address, not in the same cycle
   assign pif.load_upper = wr_upper;
   assign pif.load_lower = wr_lower;
   assign pif.wdata      = bus_wdata_i;
   assign pif.step       = ram_wr_r || rd_step_r;

   always_comb
   begin
      cfg_nxt      = cfg_r;
      rdata_nxt    = rdata_r;
      prefetch_nxt = prefetch_r;
      wdata_nxt    = wdata_r;
      ram_wr_nxt   = 1'b0;
      rd_step_nxt  = 1'b0;
      ptr_load_nxt = wr_upper || wr_lower;
      pend_nxt     = pend_r || ptr_load_r || rd_step_r;
      fetch_nxt    = fetch_r;

      // Soft reset bit is plain storage; it never clears the register itself
      if (wr_cfg)
      begin
         cfg_nxt = bus_wdata_i;
      end
      if (wr_data && !pif.read_direction)
      begin
         ram_wr_nxt = 1'b1;
         wdata_nxt  = bus_wdata_i;
      end

      if (bus_rd_i)
      begin
         if (hit(bus_addr_i, `OFS_PTR_UPPER))
         begin
            // Undefined bits read as zero
            rdata_nxt = {pif.read_direction, pif.pointer_step_enable,
                         `UPR_RSVD_VALUE, pif.addr[9:8]};
         end
         else if (hit(bus_addr_i, `OFS_PTR_LOWER))
         begin
            rdata_nxt = pif.addr[7:0];
         end
         else if (rd_data)
         begin
            rdata_nxt   = prefetch_r;
            rd_step_nxt = pif.read_direction;
         end
         else if (hit(bus_addr_i, `OFS_CONFIG))
         begin
            rdata_nxt = cfg_r;
         end
         else
         begin
            rdata_nxt = `BYTE_ZERO;
         end
      end

      // Prefetch so a read of the data port answers in one cycle
      case (fetch_r)
         FETCH_IDLE:
         begin
            if (pend_r && pif.read_direction && !ptr_load_r && !rd_step_r)
            begin
               pend_nxt  = 1'b0;
               fetch_nxt = FETCH_ISSUE;
            end
            else if (pend_r && !pif.read_direction)
            begin
               pend_nxt = 1'b0;
            end
         end
         FETCH_ISSUE:
         begin
            fetch_nxt = FETCH_CAPTURE;
         end
         FETCH_CAPTURE:
         begin
            prefetch_nxt = ram_rdata_i;
            fetch_nxt    = FETCH_IDLE;
         end
         default:
         begin
            fetch_nxt = FETCH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_r      <= `CFG_RESET;
         rdata_r    <= `BYTE_ZERO;
         prefetch_r <= `BYTE_ZERO;
         wdata_r    <= `BYTE_ZERO;
         ram_wr_r   <= 1'b0;
         rd_step_r  <= 1'b0;
         ptr_load_r <= 1'b0;
         pend_r     <= 1'b0;
         fetch_r    <= FETCH_IDLE;
      end
      else
      begin
         cfg_r      <= cfg_nxt;
         rdata_r    <= rdata_nxt;
         prefetch_r <= prefetch_nxt;
         wdata_r    <= wdata_nxt;
         ram_wr_r   <= ram_wr_nxt;
         rd_step_r  <= rd_step_nxt;
         ptr_load_r <= ptr_load_nxt;
         pend_r     <= pend_nxt;
         fetch_r    <= fetch_nxt;
      end
   end

   assign bus_rdata_o = rdata_r;
   assign ram_addr_o  = pif.addr;
   assign ram_wr_o    = ram_wr_r;
   assign ram_rd_o    = (fetch_r == FETCH_ISSUE);
   assign ram_wdata_o = wdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Core control, line gating and timeout selection

   logic       gate;
   logic       pa_n_r;
   logic       pa_n_nxt;
   logic       pb_n_r;
   logic       pb_n_nxt;
   logic       den_n_r;
   logic       den_n_nxt;
   logic       srst_r;
   logic       srst_nxt;
   logic       reinit_r;
   logic       reinit_nxt;
   logic       chain_r;
   logic       chain_nxt;
   logic [1:0] tsel;
   cycles_t    resp_r;
   cycles_t    resp_nxt;
   cycles_t    idle_r;
   cycles_t    idle_nxt;
   cycles_t    recon_r;
   cycles_t    recon_nxt;

   assign gate = cfg_r[`CFG_TXGATE_BIT];
   assign tsel = {cfg_r[`CFG_TO_HI_BIT], cfg_r[`CFG_TO_LO_BIT]};

   always_comb
   begin
      pa_n_nxt   = !(gate && tx_pulse_a_req_i);
      // In backplane mode the second pulse pin is not under the gate
      pb_n_nxt   = backplane_mode_i ? !tx_pulse_b_req_i
                                    : !(gate && tx_pulse_b_req_i);
      den_n_nxt  = !(gate && tx_driver_req_i);
      srst_nxt   = cfg_r[`CFG_SRST_BIT];
      // Only status, next-id and diagnostics see this; pointer and config do not
      reinit_nxt = cfg_r[`CFG_SRST_BIT];
      chain_nxt  = cfg_r[`CFG_CHAIN_BIT];
      resp_nxt   = pick(tsel, RESP00_CYC, RESP01_CYC, RESP10_CYC, RESP11_CYC);
      idle_nxt   = pick(tsel, IDLE00_CYC, IDLE01_CYC, IDLE10_CYC, IDLE11_CYC);
      recon_nxt  = pick(tsel, RECON_CYC, RECON_CYC, RECON_CYC, RECON11_CYC);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pa_n_r   <= 1'b1;
         pb_n_r   <= 1'b1;
         den_n_r  <= 1'b1;
         srst_r   <= 1'b0;
         reinit_r <= 1'b1;
         chain_r  <= 1'b0;
         resp_r   <= RESP00_CYC;
         idle_r   <= IDLE00_CYC;
         recon_r  <= RECON_CYC;
      end
      else
      begin
         pa_n_r   <= pa_n_nxt;
         pb_n_r   <= pb_n_nxt;
         den_n_r  <= den_n_nxt;
         srst_r   <= srst_nxt;
         reinit_r <= reinit_nxt;
         chain_r  <= chain_nxt;
         resp_r   <= resp_nxt;
         idle_r   <= idle_nxt;
         recon_r  <= recon_nxt;
      end
   end

   assign line_drive_pulse_a_n_o   = pa_n_r;
   assign line_drive_pulse_b_n_o   = pb_n_r;
   assign line_driver_enable_n_o   = den_n_r;
   assign core_soft_reset_o        = srst_r;
   assign status_reinit_o          = reinit_r;
   assign chained_command_enable_o = chain_r;
   assign timeout_select_o         = tsel;
   assign response_cycles_o        = resp_r;
   assign idle_cycles_o            = idle_r;
   assign reconfig_cycles_o        = recon_r;

endmodule : token_net_host_pointer_config

// >>> token_net_host_pointer_config_asserts.sv
`timescale 1ns/1ps
`include "token_net_regs.svh"
module token_net_host_pointer_config_asserts
   import token_net_pkg::*;
#(
   parameter cycles_t RESP00_CYC = 32'h0,
   parameter cycles_t RESP01_CYC = 32'h0,
   parameter cycles_t RESP10_CYC = 32'h0,
   parameter cycles_t IDLE00_CYC = 32'h0,
   parameter cycles_t IDLE01_CYC = 32'h0,
   parameter cycles_t IDLE10_CYC = 32'h0
)
(
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_i,
   // Register bus
   input wire logic [7:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic       bus_wr_i,
   input wire logic       bus_rd_i,
   input wire logic [7:0] bus_rdata_o,
   // RAM and line side
   input wire logic [9:0] ram_addr_o,
   input wire logic       ram_wr_o,
   input wire logic [7:0] ram_wdata_o,
   input wire logic       tx_pulse_a_req_i,
   input wire logic       tx_driver_req_i,
   input wire logic       line_drive_pulse_a_n_o,
   input wire logic       line_driver_enable_n_o,
   // Core control
   input wire logic       core_soft_reset_o,
   input wire logic       chained_command_enable_o,
   input wire logic [1:0] timeout_select_o,
   input cycles_t         response_cycles_o,
   input cycles_t         idle_cycles_o
);
   logic [7:0] cfg_r, cfg_nxt;
   logic       dir_r, dir_nxt, step_r, step_nxt;
   cycles_t    exp_resp, exp_idle;

   // Shadow of the written register state, for gating and direction
   always_comb
   begin
      cfg_nxt = cfg_r;
      dir_nxt = dir_r;
      step_nxt = step_r;
      if (bus_wr_i && bus_addr_i == `OFS_CONFIG)
         cfg_nxt = bus_wdata_i;
      if (bus_wr_i && bus_addr_i == `OFS_PTR_UPPER)
      begin
         dir_nxt = bus_wdata_i[7];
         step_nxt = bus_wdata_i[6];
      end
   end

   always_ff @(posedge clk_i)
   begin
      cfg_r <= rst_i ? 8'h00 : cfg_nxt;
      dir_r <= rst_i ? 1'b0 : dir_nxt;
      step_r <= rst_i ? 1'b0 : step_nxt;
   end

   // Code 11 falls back to the code-10 figures
   assign exp_resp = (timeout_select_o == 2'b00) ? RESP00_CYC :
                     (timeout_select_o == 2'b01) ? RESP01_CYC : RESP10_CYC;
   assign exp_idle = (timeout_select_o == 2'b00) ? IDLE00_CYC :
                     (timeout_select_o == 2'b01) ? IDLE01_CYC : IDLE10_CYC;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_cfg_wr;
      bus_wr_i && bus_addr_i == `OFS_CONFIG;
   endsequence
   sequence s_data_wr;
      bus_wr_i && bus_addr_i == `OFS_RAM_DATA && !dir_r;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   a_cfg_readback: assert property (bus_rd_i && bus_addr_i == `OFS_CONFIG
      |=> bus_rdata_o == $past(cfg_r)) else $error("config readback wrong");
   a_soft_rst_follow: assert property (s_cfg_wr
      |-> ##2 core_soft_reset_o == $past(bus_wdata_i[7], 2)) else $error("soft reset wrong");
   a_chain_follow: assert property (s_cfg_wr
      |-> ##2 chained_command_enable_o == $past(bus_wdata_i[6], 2)) else $error("chain wrong");
   a_timeout_sel: assert property (s_cfg_wr
      |=> timeout_select_o == $past(bus_wdata_i[4:3])) else $error("timeout select wrong");
   a_count_select: assert property (response_cycles_o == $past(exp_resp)
      && idle_cycles_o == $past(exp_idle)) else $error("timeout counts wrong");
   a_gate_hold: assert property (!$past(cfg_r[5])
      |-> line_driver_enable_n_o && line_drive_pulse_a_n_o) else $error("line not held");
   a_gate_pass: assert property ($past(cfg_r[5])
      |-> line_driver_enable_n_o == !$past(tx_driver_req_i)
          && line_drive_pulse_a_n_o == !$past(tx_pulse_a_req_i)) else $error("line not passed");
   a_ram_write: assert property (s_data_wr
      |=> ram_wr_o && ram_wdata_o == $past(bus_wdata_i)) else $error("ram write wrong");
   a_write_refused: assert property (bus_wr_i && bus_addr_i == `OFS_RAM_DATA && dir_r
      |=> !ram_wr_o) else $error("write in read mode");
   a_ptr_step: assert property (s_data_wr ##1 !bus_wr_i
      |=> ram_addr_o == $past(ram_addr_o) + {9'h000, $past(step_r, 2)}) else $error("step wrong");
   a_rsvd_zero: assert property (bus_rd_i && bus_addr_i == `OFS_PTR_UPPER
      |=> bus_rdata_o[5:2] == `UPR_RSVD_VALUE) else $error("reserved bits not zero");
endmodule : token_net_host_pointer_config_asserts

bind token_net_host_pointer_config token_net_host_pointer_config_asserts #(
   .RESP00_CYC(RESP00_CYC), .RESP01_CYC(RESP01_CYC), .RESP10_CYC(RESP10_CYC),
   .IDLE00_CYC(IDLE00_CYC), .IDLE01_CYC(IDLE01_CYC), .IDLE10_CYC(IDLE10_CYC)
) u_asserts (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
   .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
   .bus_rdata_o(bus_rdata_o), .ram_addr_o(ram_addr_o), .ram_wr_o(ram_wr_o),
   .ram_wdata_o(ram_wdata_o), .tx_pulse_a_req_i(tx_pulse_a_req_i),
   .tx_driver_req_i(tx_driver_req_i), .line_drive_pulse_a_n_o(line_drive_pulse_a_n_o),
   .line_driver_enable_n_o(line_driver_enable_n_o), .core_soft_reset_o(core_soft_reset_o),
   .chained_command_enable_o(chained_command_enable_o),
   .timeout_select_o(timeout_select_o), .response_cycles_o(response_cycles_o),
   .idle_cycles_o(idle_cycles_o));

// >>> host_model.sv
`timescale 1ns/1ps
module host_model
(
   // Clock
   input  wire logic       clk_i,
   // Register bus
   output logic      [7:0] bus_addr_o,
   output logic      [7:0] bus_wdata_o,
   output logic            bus_wr_o,
   output logic            bus_rd_o,
   input  wire logic [7:0] bus_rdata_i,
   // Packet RAM
   input  wire logic [9:0] ram_addr_i,
   input  wire logic       ram_wr_i,
   input  wire logic       ram_rd_i,
   input  wire logic [7:0] ram_wdata_i,
   output logic      [7:0] ram_rdata_o
);
   logic [7:0] mem [1024];

   initial
   begin
      bus_addr_o = 8'h00;
      bus_wdata_o = 8'h00;
      bus_wr_o = 1'b0;
      bus_rd_o = 1'b0;
      ram_rdata_o = 8'h5A;
   end

   // Read data is valid only the cycle after a read; otherwise it toggles
   always @(posedge clk_i)
   begin
      if (ram_wr_i)
         mem[ram_addr_i] <= ram_wdata_i;
      ram_rdata_o <= ram_rd_i ? mem[ram_addr_i] : ~ram_rdata_o;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      bus_addr_o = a;
      bus_wdata_o = d;
      bus_wr_o = 1'b1;
      @(posedge clk_i);
      #1;
      bus_wr_o = 1'b0;
      bus_addr_o = ~bus_addr_o;
      bus_wdata_o = ~bus_wdata_o;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1;
      bus_addr_o = a;
      bus_rd_o = 1'b1;
      @(posedge clk_i);
      #1;
      bus_rd_o = 1'b0;
      bus_addr_o = ~bus_addr_o;
      d = bus_rdata_i;
   endtask : rd
endmodule : host_model

// >>> token_net_host_pointer_config_test.sv
`timescale 1ns/1ps
`include "token_net_regs.svh"
module token_net_host_pointer_config_test;
   import token_net_pkg::*;
   localparam cycles_t R00 = 32'h14, R01 = 32'h0A, R10 = 32'h05;
   localparam cycles_t I00 = 32'h18, I01 = 32'h0C, I10 = 32'h06, RC = 32'h28;

   logic       clk_i = 1'b0, rst_i = 1'b1;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, ram_wdata, ram_rdata, v;
   logic       bus_wr, bus_rd, ram_wr, ram_rd, pin_a_n, pin_b_n, drv_n;
   logic       tx_a = 1'b0, tx_b = 1'b0, tx_drv = 1'b0, backplane = 1'b0;
   logic       soft_rst, reinit, chain;
   logic [9:0] ram_addr;
   logic [1:0] tsel;
   cycles_t    resp, idle, recon;
   int         n_fail = 0, n_compared = 0, cyc = 0;

   always #2.5 clk_i = ~clk_i;

   host_model u_host_model (.clk_i(clk_i), .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata),
      .bus_wr_o(bus_wr), .bus_rd_o(bus_rd), .bus_rdata_i(bus_rdata), .ram_addr_i(ram_addr),
      .ram_wr_i(ram_wr), .ram_rd_i(ram_rd), .ram_wdata_i(ram_wdata), .ram_rdata_o(ram_rdata));

   token_net_host_pointer_config #(.RESP00_CYC(R00), .RESP01_CYC(R01), .RESP10_CYC(R10),
      .IDLE00_CYC(I00), .IDLE01_CYC(I01), .IDLE10_CYC(I10), .RECON_CYC(RC))
   u_token_net_host_pointer_config (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr),
      .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata),
      .ram_addr_o(ram_addr), .ram_wr_o(ram_wr), .ram_rd_o(ram_rd), .ram_wdata_o(ram_wdata),
      .ram_rdata_i(ram_rdata), .tx_pulse_a_req_i(tx_a), .tx_pulse_b_req_i(tx_b),
      .tx_driver_req_i(tx_drv), .backplane_mode_i(backplane), .line_drive_pulse_a_n_o(pin_a_n),
      .line_drive_pulse_b_n_o(pin_b_n), .line_driver_enable_n_o(drv_n),
      .core_soft_reset_o(soft_rst), .status_reinit_o(reinit), .chained_command_enable_o(chain),
      .timeout_select_o(tsel), .response_cycles_o(resp), .idle_cycles_o(idle),
      .reconfig_cycles_o(recon));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_cyc

   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic t_reset;
      chk({pin_a_n, pin_b_n, drv_n, soft_rst, tsel}, 6'h38);
      chk({resp, idle, recon}, {R00, I00, RC});
      u_host_model.rd(`OFS_CONFIG, v);
      chk(v, `CFG_RESET);
      u_host_model.wr(8'hF0, 8'hFF);
      u_host_model.rd(8'hF0, v);
      chk(v, 8'h00);
      u_host_model.rd(`OFS_CONFIG, v);
      chk(v, `CFG_RESET);
      $display("Test reset done");
   endtask : t_reset

   task automatic t_timeouts;
      // Code 11 falls back to the code-10 figures
      cycles_t er[4] = '{R00, R01, R10, R10};
      cycles_t ei[4] = '{I00, I01, I10, I10};
      for (int c = 0; c < 4; c++)
      begin
         u_host_model.wr(`OFS_CONFIG, {1'b0, c[0], 1'b0, c[1:0], 3'b000});
         wait_cyc(3);
         chk({tsel, chain}, {c[1:0], c[0]});
         chk({resp, idle, recon}, {er[c], ei[c], RC});
      end
      $display("Test timeouts done");
   endtask : t_timeouts

   task automatic t_gate;
      tx_a = 1'b1;
      tx_b = 1'b1;
      tx_drv = 1'b1;
      u_host_model.wr(`OFS_CONFIG, 8'h00);
      wait_cyc(3);
      chk({pin_a_n, pin_b_n, drv_n}, 3'h7);
      backplane = 1'b1;
      wait_cyc(3);
      chk({pin_a_n, pin_b_n, drv_n}, 3'h5);
      backplane = 1'b0;
      // Gate opened once, after node identity settles, and left open
      u_host_model.wr(`OFS_CONFIG, 8'h20);
      wait_cyc(3);
      chk({pin_a_n, pin_b_n, drv_n}, 3'h0);
      $display("Test gate done");
   endtask : t_gate

   task automatic t_soft_reset;
      logic [9:0] p;
      // Non-zero pointer, so a wrongly cleared one shows
      u_host_model.wr(`OFS_PTR_LOWER, 8'h5C);
      p = ram_addr;
      u_host_model.wr(`OFS_CONFIG, 8'hA8);
      wait_cyc(3);
      chk({soft_rst, reinit, ram_addr}, {2'b11, p});
      u_host_model.rd(`OFS_CONFIG, v);
      chk(v, 8'hA8);
      u_host_model.wr(`OFS_CONFIG, 8'h28);
      wait_cyc(3);
      chk({soft_rst, reinit}, 2'b00);
      $display("Test soft reset done");
   endtask : t_soft_reset

   task automatic t_ptr_write;
      logic [7:0] up[4] = '{8'h7F, 8'h40, 8'h00, 8'h41};
      logic [7:0] lo[4] = '{8'hFF, 8'h00, 8'h10, 8'hFF};
      logic [9:0] nx[4] = '{10'h000, 10'h001, 10'h010, 10'h200};
      for (int i = 0; i < 4; i++)
      begin
         u_host_model.wr(`OFS_PTR_UPPER, up[i]);
         u_host_model.wr(`OFS_PTR_LOWER, lo[i]);
         u_host_model.rd(`OFS_PTR_UPPER, v);
         chk(v, up[i] & 8'hC3);
         u_host_model.wr(`OFS_RAM_DATA, 8'hA0 + 8'(i));
         chk({ram_wr, ram_wdata}, {1'b1, 8'hA0 + 8'(i)});
         chk(ram_addr, {up[i][1:0], lo[i]});
         wait_cyc(1);
         chk(ram_addr, nx[i]);
      end
      $display("Test pointer write done");
   endtask : t_ptr_write

   task automatic t_ptr_read;
      u_host_model.wr(`OFS_PTR_UPPER, 8'hC3);
      u_host_model.wr(`OFS_PTR_LOWER, 8'hFF);
      wait_cyc(6);
      u_host_model.rd(`OFS_RAM_DATA, v);
      chk(v, 8'hA0);
      wait_cyc(6);
      u_host_model.rd(`OFS_RAM_DATA, v);
      chk(v, 8'hA1);
      u_host_model.wr(`OFS_RAM_DATA, 8'h99);
      chk(ram_wr, 1'b0);
      u_host_model.wr(`OFS_PTR_UPPER, 8'h80);
      u_host_model.wr(`OFS_PTR_LOWER, 8'h10);
      for (int i = 0; i < 2; i++)
      begin
         wait_cyc(6);
         u_host_model.rd(`OFS_RAM_DATA, v);
         chk(v, 8'hA2);
      end
      $display("Test pointer read done");
   endtask : t_ptr_read

   task automatic t_mid_reset;
      rst_i = 1'b1;
      wait_cyc(2);
      chk(reinit, 1'b1);
      rst_i = 1'b0;
      wait_cyc(2);
      chk({pin_a_n, pin_b_n, drv_n, ram_addr}, {3'h7, `PTR_ADDR_RESET});
      u_host_model.rd(`OFS_CONFIG, v);
      chk(v, `CFG_RESET);
      $display("Test mid reset done");
   endtask : t_mid_reset

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, cyc, 0);
         test_done();
      end
   end

   initial
   begin
      repeat (16) @(posedge clk_i);
      #1;
      chk(reinit, 1'b1);
      rst_i = 1'b0;
      wait_cyc(1);
      t_reset();
      t_timeouts();
      t_gate();
      t_soft_reset();
      t_ptr_write();
      t_ptr_read();
      t_mid_reset();
      test_done();
   end
endmodule : token_net_host_pointer_config_test
